/* File: rtl/ffs_pkg.sv */
//
// Purpose: Shared constants and types for the fan fault supervisor.
// Assumes: Analog comparators sit outside and deliver synchronous levels.
// Notes:   All periods are counted in PWM cycles except the sense blanking.
//
package ffs_pkg;

    // ------------------------------------------------------------------
    // Clock and blanking time
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_TIME_NS = 1000;
    // Least time: round up to whole cycles, never below one
    localparam int BLANK_CYCLES_I =
        (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BLANK_CYCLES =
        8'((BLANK_CYCLES_I < 1) ? 1 : BLANK_CYCLES_I);

    // ------------------------------------------------------------------
    // Counts in PWM cycles and pulses
    // ------------------------------------------------------------------
    localparam logic [5:0] MISS_CYCLES    = 6'h20;  // 32 missing cycles
    localparam logic [5:0] DIAG_CYCLES    = 6'h03;  // 3 diagnostic cycles
    localparam logic [5:0] START_CYCLES   = 6'h20;  // 32 start-up cycles
    localparam logic [5:0] WINDOW_CYCLES  = 6'h20;  // 32 cycle fault window
    localparam logic [4:0] RECOVER_PULSES = 5'h10;  // 16 pulses to recover

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] CNT_RESET   = 6'h00;
    localparam logic [4:0] PULSE_RESET = 5'h00;
    localparam logic [7:0] BLANK_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Supervisor states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FFS_SLEEP,     // Shutdown, drive low, alarm released
        FFS_START1,    // First start-up period
        FFS_START2,    // Repeat start-up period
        FFS_RUN,       // Normal PWM
        FFS_DIAG,      // Diagnostic full drive
        FFS_DSTART,    // Start-up after diagnostic
        FFS_FAULT      // Fan fault, full drive, alarm low
    } ffs_state_t;

    // ------------------------------------------------------------------
    // Analog front end levels and strobes
    // ------------------------------------------------------------------
    typedef struct packed {
        logic temp_above_ramp;   // temperature_level above ramp
        logic floor_above_ramp;  // floor_level above ramp
        logic overheat_reached;  // temperature_level at overheat_threshold
        logic overheat_cleared;  // below threshold by overheat_hysteresis
        logic below_sleep;       // floor_level below sleep_threshold
        logic above_wake;        // floor_level above wake_threshold
        logic pulse;             // Commutation pulse strobe
        logic cycle;             // PWM cycle boundary strobe
    } ffs_front_t;

endpackage

/* File: rtl/ffs_supervisor.sv */
//
// Purpose: Fan drive supervisor with missing-pulse detection and restart.
// Assumes: Front end strobes are one clk_in cycle wide and synchronous.
// Notes:   Alarm is open drain: alarm_out is always low, enable low drives.
//
// Notes on behaviour
// - Alarm is active-low open drain output.
// - Overheat variant alarms at overheat threshold.
// - Overheat alarm clears only after full hysteresis.
// - Thirty-two missing cycles start diagnostic period.
// - Diagnostic drives high three cycles; pulse resumes.
// - Failed diagnostic runs 32-cycle start-up, pulse resumes.
// - Failed start-up after diagnostic enters fan fault.
// - Fault keeps alarm low, drive high, monitoring.
// - Sixteen pulses in 32 cycles clear fault.
// - Shutdown in fault releases alarm, drives low.
// - Fault drives full duty; afterwards the higher of temperature and floor applies.
// - Accepted pulse, unless first after turn-on, clears missing-pulse timer.
// - Pulses ignored during blanking after drive rise.
// - First pulse after each turn-on discarded in PWM.
// - Parameter removes the overheat alarm path.
// - Power-up start-up runs twice, then fault.
// - Shutdown holds drive low, alarm inactive.
// - Duty follows higher of temperature and floor.
//
`timescale 1ns/1ns

module ffs_supervisor #(
    parameter bit OVERHEAT_EN = 1'b1   // Overheat alarm variant
) (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // Analog front end
    input  wire ffs_pkg::ffs_front_t front_in,
    // Fan drive
    output logic                    drive_out,
    // Open-drain alarm
    output logic                    alarm_out,
    output logic                    alarm_oe_n_out,
    // Status
    output logic                    fan_fault_out,
    output logic                    overheat_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ffs_pkg::ffs_state_t state_reg;
    ffs_pkg::ffs_state_t state_next;
    logic [5:0]          cnt_reg;
    logic [4:0]          pulse_cnt_reg;
    logic [7:0]          blank_cnt_reg;
    logic                first_taken_reg;
    logic                overheat_reg;
    logic                drive_reg;
    logic                drive_next;
    logic                alarm_oe_n_reg;
    logic                fan_fault_reg;
    logic                accepted;
    logic                good_pulse;
    logic                cnt_done;
    logic [5:0]          cnt_limit;
    logic                alarm_next;

    // ------------------------------------------------------------------
    // Pulse qualification
    // ------------------------------------------------------------------

    // Pulse seen outside the blanking interval
    assign accepted = front_in.pulse &&
                      (blank_cnt_reg == ffs_pkg::BLANK_RESET);

    // First pulse of each turn-on is a locked-rotor artefact; it is
    // dropped in every state, else a stalled fan that the diagnostic
    // turns on would look alive and the fault would never be raised
    assign good_pulse = accepted && first_taken_reg;

    // Blanking counter, reloaded at each drive rise
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            blank_cnt_reg <= ffs_pkg::BLANK_RESET;
        end else if (drive_next && !drive_reg) begin
            blank_cnt_reg <= ffs_pkg::BLANK_CYCLES;
        end else if (blank_cnt_reg != ffs_pkg::BLANK_RESET) begin
            blank_cnt_reg <= blank_cnt_reg - 8'h01;
        end
    end

    // Initial pulse blanker, armed at each drive rise
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            first_taken_reg <= 1'b0;
        end else if (drive_next && !drive_reg) begin
            first_taken_reg <= 1'b0;
        end else if (accepted) begin
            first_taken_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Cycle counter limit per state
    // ------------------------------------------------------------------

    // Length of the current timed period in PWM cycles
    always_comb begin
        case (state_reg)
            ffs_pkg::FFS_RUN:   cnt_limit = ffs_pkg::MISS_CYCLES;
            ffs_pkg::FFS_DIAG:  cnt_limit = ffs_pkg::DIAG_CYCLES;
            ffs_pkg::FFS_FAULT: cnt_limit = ffs_pkg::WINDOW_CYCLES;
            default:            cnt_limit = ffs_pkg::START_CYCLES;
        endcase
    end

    // Last cycle of the period ends with this strobe
    assign cnt_done = front_in.cycle &&
                      (cnt_reg == cnt_limit - 6'h01);

    // ------------------------------------------------------------------
    // State sequencing
    // ------------------------------------------------------------------

    // Next state; shutdown overrides every other state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ffs_pkg::FFS_SLEEP: begin
                if (front_in.above_wake) begin
                    state_next = ffs_pkg::FFS_START1;
                end
            end
            ffs_pkg::FFS_START1: begin
                if (good_pulse) begin
                    state_next = ffs_pkg::FFS_RUN;
                end else if (cnt_done) begin
                    state_next = ffs_pkg::FFS_START2;
                end
            end
            ffs_pkg::FFS_START2: begin
                if (good_pulse) begin
                    state_next = ffs_pkg::FFS_RUN;
                end else if (cnt_done) begin
                    state_next = ffs_pkg::FFS_FAULT;
                end
            end
            ffs_pkg::FFS_RUN: begin
                if (!good_pulse && cnt_done) begin
                    state_next = ffs_pkg::FFS_DIAG;
                end
            end
            ffs_pkg::FFS_DIAG: begin
                if (good_pulse) begin
                    state_next = ffs_pkg::FFS_RUN;
                end else if (cnt_done) begin
                    state_next = ffs_pkg::FFS_DSTART;
                end
            end
            ffs_pkg::FFS_DSTART: begin
                if (good_pulse) begin
                    state_next = ffs_pkg::FFS_RUN;
                end else if (cnt_done) begin
                    state_next = ffs_pkg::FFS_FAULT;
                end
            end
            ffs_pkg::FFS_FAULT: begin
                if (good_pulse &&
                    (pulse_cnt_reg == ffs_pkg::RECOVER_PULSES - 5'h01)) begin
                    state_next = ffs_pkg::FFS_RUN;
                end
            end
            default: begin
                state_next = ffs_pkg::FFS_START1;
            end
        endcase
        if (front_in.below_sleep) begin
            state_next = ffs_pkg::FFS_SLEEP;
        end
    end

    // State register; reset counts as power-up
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= ffs_pkg::FFS_START1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Cycle counter: restarts on state change and on a good pulse in RUN
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_reg <= ffs_pkg::CNT_RESET;
        end else if (state_next != state_reg) begin
            cnt_reg <= ffs_pkg::CNT_RESET;
        end else if (good_pulse && state_reg == ffs_pkg::FFS_RUN) begin
            cnt_reg <= ffs_pkg::CNT_RESET;
        end else if (cnt_done) begin
            cnt_reg <= ffs_pkg::CNT_RESET;
        end else if (front_in.cycle) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    // Pulse counter for the recovery window
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pulse_cnt_reg <= ffs_pkg::PULSE_RESET;
        end else if (state_reg != ffs_pkg::FFS_FAULT) begin
            pulse_cnt_reg <= ffs_pkg::PULSE_RESET;
        end else if (cnt_done) begin
            // A pulse on the window's last strobe opens the next window
            pulse_cnt_reg <= good_pulse ? 5'h01 : ffs_pkg::PULSE_RESET;
        end else if (good_pulse) begin
            pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Overheat flag with hysteresis
    // ------------------------------------------------------------------

    // Set at threshold, clear only once fully below the hysteresis band
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            overheat_reg <= 1'b0;
        end else if (!OVERHEAT_EN) begin
            overheat_reg <= 1'b0;
        end else if (front_in.overheat_reached) begin
            overheat_reg <= 1'b1;
        end else if (front_in.overheat_cleared) begin
            overheat_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Drive and alarm
    // ------------------------------------------------------------------

    // Drive level for the next cycle
    always_comb begin
        case (state_next)
            ffs_pkg::FFS_SLEEP: drive_next = 1'b0;
            ffs_pkg::FFS_RUN: begin
                // Higher level wins; after a fault the same rule applies
                drive_next = front_in.temp_above_ramp ||
                             front_in.floor_above_ramp;
            end
            ffs_pkg::FFS_FAULT: drive_next = 1'b1;
            default:            drive_next = 1'b1;
        endcase
    end

    // Alarm from fan fault, or overheat unless asleep
    assign alarm_next = (state_next == ffs_pkg::FFS_FAULT) ||
                        (OVERHEAT_EN && overheat_reg &&
                         state_next != ffs_pkg::FFS_SLEEP);

    // Output flip-flops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            drive_reg      <= 1'b0;
            alarm_oe_n_reg <= 1'b1;
            fan_fault_reg  <= 1'b0;
        end else begin
            drive_reg      <= drive_next;
            alarm_oe_n_reg <= !alarm_next;
            fan_fault_reg  <= (state_next == ffs_pkg::FFS_FAULT);
        end
    end

    // Open-drain pin never drives high
    always_ff @(posedge clk_in) begin
        alarm_out <= 1'b0;
    end

    assign drive_out      = drive_reg;
    assign alarm_oe_n_out = alarm_oe_n_reg;
    assign fan_fault_out  = fan_fault_reg;
    assign overheat_out   = overheat_reg;

endmodule

/* File: sim/ffs_supervisor_chk.sv */
// Purpose: Port assertions for the fan fault supervisor.
// Assumes: Bound to every ffs_supervisor instance.
// Notes:   Front end inputs are watched only as causes.
`timescale 1ns/1ns

module ffs_supervisor_chk #(
    parameter bit OVERHEAT_EN = 1'b1
) (
    // Clock and reset
    input wire logic                clk_in,
    input wire logic                rst_in,
    // Watched ports
    input wire ffs_pkg::ffs_front_t front_in,
    input wire logic                drive_out,
    input wire logic                alarm_out,
    input wire logic                alarm_oe_n_out,
    input wire logic                fan_fault_out,
    input wire logic                overheat_out
);
    // ---------------------------------------------------------------
    // Output relations
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_alarm_data_low:
    assert property (alarm_out == 1'b0) else $error("alarm data high");
    chk_alarm_has_cause:
    assert property (!alarm_oe_n_out |-> fan_fault_out || $past(overheat_out))
        else $error("alarm without cause");
    chk_fault_full_drive:
    assert property (fan_fault_out |-> drive_out && !alarm_oe_n_out)
        else $error("fault without drive or alarm");
    chk_fault_on_cycle:
    assert property ($rose(fan_fault_out) |-> $past(front_in.cycle))
        else $error("fault entered off a cycle strobe");
    chk_fault_exit_cause:
    assert property ($fell(fan_fault_out) && !$past(rst_in) |->
        $past(front_in.pulse) || $past(front_in.below_sleep))
        else $error("fault left without pulse or sleep");
    chk_sleep_outputs:
    assert property (front_in.below_sleep |=>
        !drive_out && alarm_oe_n_out && !fan_fault_out)
        else $error("sleep outputs wrong");
    chk_start_drive:
    assert property ($past(rst_in) && !front_in.below_sleep |=> drive_out)
        else $error("no drive after reset");
    chk_overheat_set:
    assert property (OVERHEAT_EN && front_in.overheat_reached &&
        !front_in.below_sleep |=> overheat_out) else $error("overheat missed");
    chk_overheat_hold:
    assert property (overheat_out && !front_in.overheat_cleared &&
        !front_in.below_sleep |=> overheat_out) else $error("overheat lost");
    chk_overheat_clear:
    assert property (overheat_out && front_in.overheat_cleared &&
        !front_in.overheat_reached |=> !overheat_out)
        else $error("overheat stuck");

    // Main scenarios reached
    cover property ($rose(fan_fault_out));
    cover property ($fell(fan_fault_out) && $past(front_in.pulse));
    cover property ($rose(overheat_out));
    cover property (front_in.below_sleep && fan_fault_out);
endmodule

bind ffs_supervisor ffs_supervisor_chk #(.OVERHEAT_EN(OVERHEAT_EN)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .front_in(front_in),
    .drive_out(drive_out), .alarm_out(alarm_out),
    .alarm_oe_n_out(alarm_oe_n_out), .fan_fault_out(fan_fault_out),
    .overheat_out(overheat_out));

/* File: sim/ffs_fan_model.sv */
// Purpose: Behavioural fan with current sense strobe.
// Assumes: Commutation pulses only while the drive is on.
// Notes:   Mode 0 stopped, 1 spinning, 2 locked rotor.
`timescale 1ns/1ns

module ffs_fan_model (
    // Clock
    input  wire logic       clk_in,
    // Fan side
    input  wire logic       drive_in,
    input  wire logic [1:0] mode_in,
    input  wire logic [7:0] gap_in,
    // Sense strobe
    output logic            pulse_out = 1'b0
);
    int   on_cnt  = 0;
    logic drive_d = 1'b0;

    // Counts clocks since turn-on, emits one-clock strobes
    always @(negedge clk_in) begin
        drive_d <= drive_in;
        on_cnt  <= (drive_in && !drive_d) ? 0 : on_cnt + 1;
        case (mode_in)
            2'h1: pulse_out <= drive_in &&
                (on_cnt % int'(gap_in) == int'(gap_in) - 1);
            2'h2: pulse_out <= drive_in && on_cnt == 120; // Turn-on only
            default: pulse_out <= 1'b0;
        endcase
    end
endmodule

/* File: sim/ffs_supervisor_tb.sv */
// Purpose: Self-checking bench for the fan fault supervisor.
// Assumes: One PWM cycle is PWM_CLKS clocks of clk_in.
// Notes:   Model tracks drive, fault and overheat as integers.
`timescale 1ns/1ns

module ffs_supervisor_tb;
    localparam int PWM_CLKS = 200;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic temp_lv = 0, flr_lv = 0, oh_set = 0, oh_clr = 0;
    logic sleep_lv = 0, wake_lv = 0, cyc = 0, fan_pulse;
    logic [1:0] temp_mode = 2'h0, fan_mode = 2'h0;
    logic [7:0] fan_gap = 8'h50;
    logic drive_out, alarm_out, alarm_oe_n_out, fan_fault_out, overheat_out;
    logic var_oe_n, var_oh;
    int pcnt = 0, miscompares = 0, compares = 0, m_drv, m_flt, m_oh, t;
    ffs_pkg::ffs_front_t front;

    assign front = {temp_lv, flr_lv, oh_set, oh_clr, sleep_lv, wake_lv,
                    fan_pulse, cyc};
    // Clock
    always #5 clk_in = ~clk_in;
    // Ramp compare and cycle strobe from the front end
    always @(negedge clk_in) begin
        pcnt    <= rst_in ? 0 : (pcnt + 1) % PWM_CLKS;
        cyc     <= !rst_in && pcnt == PWM_CLKS - 1;
        temp_lv <= (temp_mode == 2'h2) ? pcnt < 160 : temp_mode[0];
    end

    ffs_supervisor dut_u (.clk_in(clk_in), .rst_in(rst_in), .front_in(front),
        .drive_out(drive_out), .alarm_out(alarm_out),
        .alarm_oe_n_out(alarm_oe_n_out), .fan_fault_out(fan_fault_out),
        .overheat_out(overheat_out));
    // Variant without the overheat path sees the same front end
    ffs_supervisor #(.OVERHEAT_EN(1'b0)) dut_plain_u (.clk_in(clk_in),
        .rst_in(rst_in), .front_in(front), .drive_out(), .alarm_out(),
        .alarm_oe_n_out(var_oe_n), .fan_fault_out(),
        .overheat_out(var_oh));
    ffs_fan_model fan_u (.clk_in(clk_in), .drive_in(drive_out),
        .mode_in(fan_mode), .gap_in(fan_gap), .pulse_out(fan_pulse));

    // Ends the run with the counts and the verdict
    task automatic give_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A bound that runs out counts as a mismatch and ends the run
    task automatic timed_out(input logic [7:0] got, input logic [7:0] exp);
        miscompares++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        give_verdict();
    endtask
    // Variant without overheat path keeps flag and alarm released
    task automatic cmp_var();
        compares++;
        if ({var_oe_n, var_oh} !== 2'b10) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time,
                {var_oe_n, var_oh}, 2'b10);
        end
    endtask
    // Compares all outputs against the model
    task automatic cmp_out();
        logic [4:0] e;
        e = {m_drv[0], 1'b0, ~(m_flt[0] | m_oh[0]), m_flt[0], m_oh[0]};
        compares++;
        if ({drive_out, alarm_out, alarm_oe_n_out, fan_fault_out,
             overheat_out} !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, {drive_out, alarm_out,
                alarm_oe_n_out, fan_fault_out, overheat_out}, e);
        end
    endtask
    // Waits n cycle strobes, then a falling edge
    task automatic strobes(input int n);
        repeat (n) begin
            t = 0;
            do begin
                @(posedge clk_in);
                t++;
            end while (!cyc && t < 2 * PWM_CLKS);
            if (!cyc) begin
                timed_out(8'(cyc), 8'h01);
            end
        end
        @(negedge clk_in);
    endtask
    // Bounded wait for a drive and fault pattern
    task automatic wait_pat(input logic [1:0] p, input int lim);
        t = 0;
        while ({drive_out, fan_fault_out} !== p && t < lim) begin
            @(negedge clk_in);
            t++;
        end
        if (t >= lim) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time,
                {drive_out, fan_fault_out}, p);
            give_verdict();
        end
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'hcf01a3b2));
        {m_drv, m_flt, m_oh} = {32'd0, 32'd0, 32'd0};
        repeat (6) @(negedge clk_in);
        cmp_out();
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        m_drv = 1;
        cmp_out();
        strobes(63);
        cmp_out();
        strobes(1);
        m_flt = 1;
        cmp_out();
        sleep_lv = 1;
        repeat (2) @(negedge clk_in);
        {m_drv, m_flt} = {32'd0, 32'd0};
        cmp_out();
        {sleep_lv, wake_lv} = 2'b01;
        repeat (2) @(negedge clk_in);
        wake_lv = 0;
        m_drv = 1;
        cmp_out();
        fan_gap = 8'(60 + $urandom % 40);
        fan_mode = 2'h1;
        wait_pat(2'b00, 64 * PWM_CLKS);
        m_drv = 0;
        cmp_out();
        flr_lv = 1;
        repeat (2) @(negedge clk_in);
        m_drv = 1;
        cmp_out();
        oh_set = 1;
        repeat (3) @(negedge clk_in);
        oh_set = 0;
        m_oh = 1;
        cmp_out();
        cmp_var();
        strobes(2);
        cmp_out();
        oh_clr = 1;
        repeat (3) @(negedge clk_in);
        oh_clr = 0;
        m_oh = 0;
        cmp_out();
        // Stop the fan right after a pulse clear of any strobe
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (!(fan_pulse && !cyc) && t < 400);
        if (!(fan_pulse && !cyc)) begin
            timed_out(8'(fan_pulse), 8'h01);
        end
        @(negedge clk_in);
        {fan_mode, flr_lv} = {2'h0, 1'b0};
        m_drv = 0;
        strobes(31);
        cmp_out();
        strobes(1);
        m_drv = 1;
        cmp_out();
        strobes(2);
        cmp_out();
        strobes(32);
        cmp_out();
        strobes(1);
        m_flt = 1;
        cmp_out();
        {fan_mode, flr_lv} = {2'h1, 1'b1};
        wait_pat(2'b10, 70 * PWM_CLKS);
        m_flt = 0;
        cmp_out();
        {fan_mode, flr_lv, temp_mode} = {2'h2, 1'b0, 2'h2};
        t = 0;
        while (!(pcnt == 180 && drive_out === 1'b1) && t < 40 * PWM_CLKS) begin
            @(negedge clk_in);
            t++;
        end
        if (!(pcnt == 180 && drive_out === 1'b1)) begin
            timed_out(8'(drive_out), 8'h01);
        end
        cmp_out();
        // Stalled rotor: diagnostic and start-up pass, then fault
        strobes(35);
        m_flt = 1;
        cmp_out();
        give_verdict();
    end
endmodule
